/* pkg/spl_pkg.sv */
package spl_pkg;
    // ==========================================
    // Setting widths and values after reset
    // ==========================================
    localparam int unsigned DETECT_W = 16;
    localparam int unsigned DEV_W = 20;
    localparam int unsigned POS_RANGE_W = 15;
    localparam logic status_sel_reset = 1'b0;
    localparam logic [DETECT_W-1:0] detect_time_invalid = 16'h03e8;
    localparam logic [3:0] stop_action_max = 4'h9;
    localparam logic [3:0] stop_action_emerg_first = 4'h8;
    localparam logic [3:0] stop_action_hold_first = 4'h4;
    // Detection time unit: 1 ms per step at 125 MHz
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned DETECT_UNIT_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_MHZ * DETECT_UNIT_US;
    localparam int unsigned TICK_W = 17;
    // Braking modes on the brake output
    typedef enum logic [1:0] {
        SPL_BRAKE_DB = 2'h0,
        SPL_BRAKE_FREE = 2'h1,
        SPL_BRAKE_EMERG = 2'h2
    } spl_brake_type;
endpackage

/* pkg/spl_stop_if.sv */
`timescale 1ns/1ps
// Stop-action decode passed from decoder to sequencer
interface spl_stop_if;
    logic [3:0] action;
    logic [1:0] decel_brake;
    logic [1:0] stall_brake;
    logic clear_dev;
    modport dec (input action, output decel_brake, output stall_brake, output clear_dev);
    modport seq (output action, input decel_brake, input stall_brake, input clear_dev);
endinterface

/* core/spl_stop_decode.sv */
`timescale 1ns/1ps
// ==========================================
// Stop-action decoder
// ==========================================
module spl_stop_decode (
    spl_stop_if.dec stop
);
    import spl_pkg::*;
    // Table lookup: bit 0 picks free-run decel, bit 1 free-run stall (bit 0 at 8..9), bit 2 picks hold, 8..9 emergency decel
    always_comb begin
        stop.decel_brake = stop.action[0] ? SPL_BRAKE_FREE : SPL_BRAKE_DB;
        stop.stall_brake = stop.action[1] ? SPL_BRAKE_FREE : SPL_BRAKE_DB;
        stop.clear_dev = 1'b1;
        if (stop.action >= stop_action_emerg_first) begin
            stop.decel_brake = SPL_BRAKE_EMERG;
            stop.stall_brake = stop.action[0] ? SPL_BRAKE_FREE : SPL_BRAKE_DB;
        end else if (stop.action >= stop_action_hold_first) begin
            stop.clear_dev = 1'b0;
        end
    end
endmodule

/* core/spl_power_loss.sv */
`timescale 1ns/1ps
module spl_power_loss (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic status_pin_select_i,
    input wire logic undervoltage_response_select_i,
    input wire logic [3:0] poweroff_stop_action_i,
    input wire logic [spl_pkg::DETECT_W-1:0] poweroff_detect_time_i,
    input wire logic main_power_ok_i,
    input wire logic bus_undervoltage_i,
    input wire logic servo_on_i,
    input wire logic cmd_done_i,
    input wire logic motor_stalled_i,
    input wire logic [spl_pkg::DEV_W-1:0] deviation_i,
    input wire logic [spl_pkg::POS_RANGE_W-1:0] in_position_range_i,
    input wire logic alarm_clear_i,
    output logic status_pin_o,
    output logic main_undervoltage_alarm_o,
    output logic servo_enable_o,
    output logic [1:0] brake_mode_o,
    output logic deviation_clear_o
);
    import spl_pkg::*;

    // ==========================================
    // Pin synchronisers
    // ==========================================
    logic pwr_meta_q, pwr_sync_q; // Main power present
    logic uv_meta_q, uv_sync_q; // DC bus below threshold
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_meta_q <= 1'b1;
            pwr_sync_q <= 1'b1;
            uv_meta_q <= 1'b0;
            uv_sync_q <= 1'b0;
        end else begin
            pwr_meta_q <= main_power_ok_i;
            pwr_sync_q <= pwr_meta_q;
            uv_meta_q <= bus_undervoltage_i;
            uv_sync_q <= uv_meta_q;
        end
    end

    // ==========================================
    // Power-off detection timer
    // ==========================================
    logic [TICK_W-1:0] tick_q; // Cycles within one time unit
    logic [DETECT_W-1:0] off_units_q; // Whole units power has been off
    logic detected; // Shutoff persisted for the detect time
    // Count off-time; any return of power restarts it
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_q <= '0;
            off_units_q <= '0;
        end else if (pwr_sync_q) begin
            tick_q <= '0;
            off_units_q <= '0;
        end else if (!detected) begin
            if (tick_q == TICK_W'(TICK_CYCLES - 1)) begin
                tick_q <= '0;
                off_units_q <= off_units_q + 1'b1;
            end else begin
                tick_q <= tick_q + 1'b1;
            end
        end
    end
    assign detected = !pwr_sync_q && (off_units_q >= poweroff_detect_time_i);

    // ==========================================
    // Stop-action decode
    // ==========================================
    spl_stop_if stop ();
    assign stop.action = (poweroff_stop_action_i > stop_action_max) ? stop_action_max : poweroff_stop_action_i;
    spl_stop_decode u_dec (
        .stop(stop)
    );

    // ==========================================
    // Power-loss sequencer
    // ==========================================
    typedef enum logic [3:0] {
        SPL_RUN = 4'h1,
        SPL_DECEL = 4'h2,
        SPL_STALL = 4'h4,
        SPL_TRIP = 4'h8
    } spl_state_type;
    spl_state_type state_q;
    logic resp_valid; // Response setting honoured
    logic trip_req; // Undervoltage trip wanted
    logic soft_off_req; // Servo-off by stop action wanted
    assign resp_valid = poweroff_detect_time_i != detect_time_invalid;
    assign trip_req = uv_sync_q
        || (detected && servo_on_i && (undervoltage_response_select_i || !resp_valid));
    assign soft_off_req = detected && resp_valid && !undervoltage_response_select_i;

    // State transitions; trip takes priority
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= SPL_RUN;
        end else begin
            case (state_q)
                SPL_RUN: begin
                    if (trip_req) begin
                        state_q <= SPL_TRIP;
                    end else if (soft_off_req) begin
                        state_q <= motor_stalled_i ? SPL_STALL : SPL_DECEL;
                    end
                end
                SPL_DECEL: begin
                    if (trip_req) begin
                        state_q <= SPL_TRIP;
                    end else if (motor_stalled_i) begin
                        state_q <= SPL_STALL;
                    end
                end
                SPL_STALL: begin
                    if (trip_req) begin
                        state_q <= SPL_TRIP;
                    end else if (pwr_sync_q) begin
                        state_q <= SPL_RUN;
                    end
                end
                SPL_TRIP: begin
                    if (alarm_clear_i && !trip_req) begin
                        state_q <= SPL_RUN;
                    end
                end
                default: begin
                    state_q <= SPL_RUN;
                end
            endcase
        end
    end

    // ==========================================
    // Outputs
    // ==========================================
    logic done_q; // Positioning complete
    logic [DEV_W-1:0] dev_mag; // Deviation magnitude
    assign dev_mag = deviation_i[DEV_W-1] ? DEV_W'(-deviation_i) : deviation_i;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= cmd_done_i && (dev_mag <= DEV_W'(in_position_range_i));
        end
    end

    // Status pin, alarm, enable, brake and deviation clear
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_pin_o <= 1'b0;
            main_undervoltage_alarm_o <= 1'b0;
            servo_enable_o <= 1'b0;
            brake_mode_o <= SPL_BRAKE_DB;
            deviation_clear_o <= 1'b0;
        end else begin
            status_pin_o <= status_pin_select_i ? (state_q == SPL_DECEL) : done_q;
            main_undervoltage_alarm_o <= (state_q == SPL_TRIP);
            servo_enable_o <= servo_on_i && (state_q == SPL_RUN);
            brake_mode_o <= (state_q == SPL_STALL) ? stop.stall_brake : stop.decel_brake;
            deviation_clear_o <= (state_q == SPL_DECEL || state_q == SPL_STALL) && stop.clear_dev;
        end
    end

    // ==========================================
    // Checks
    // ==========================================
    property p_pin_select;
        @(posedge core_clk_i) disable iff (!rstn_i)
        $stable(status_pin_select_i) && !status_pin_select_i |=> status_pin_o == $past(done_q);
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("pin not done");

    property p_decel_pin;
        @(posedge core_clk_i) disable iff (!rstn_i)
        status_pin_select_i && state_q == SPL_DECEL ##1 status_pin_select_i |-> status_pin_o;
    endproperty
    a_decel_pin: assert property (p_decel_pin) else $error("decel not shown");

    property p_no_early;
        @(posedge core_clk_i) disable iff (!rstn_i)
        state_q == SPL_RUN && !uv_sync_q && !detected |=> state_q != SPL_TRIP;
    endproperty
    a_no_early: assert property (p_no_early) else $error("early trip");

    property p_trip;
        @(posedge core_clk_i) disable iff (!rstn_i)
        state_q == SPL_RUN && detected && servo_on_i && undervoltage_response_select_i
            |=> state_q == SPL_TRIP ##1 main_undervoltage_alarm_o;
    endproperty
    a_trip: assert property (p_trip) else $error("no trip");

    property p_soft;
        @(posedge core_clk_i) disable iff (!rstn_i)
        state_q == SPL_RUN && soft_off_req && !uv_sync_q
            |=> state_q inside {SPL_DECEL, SPL_STALL} ##1 !servo_enable_o;
    endproperty
    a_soft: assert property (p_soft) else $error("no soft off");

    property p_invalid;
        @(posedge core_clk_i) disable iff (!rstn_i)
        poweroff_detect_time_i == detect_time_invalid |-> !soft_off_req;
    endproperty
    a_invalid: assert property (p_invalid) else $error("response used");

    property p_bus_uv;
        @(posedge core_clk_i) disable iff (!rstn_i)
        uv_sync_q && state_q != SPL_TRIP |=> state_q == SPL_TRIP;
    endproperty
    a_bus_uv: assert property (p_bus_uv) else $error("bus uv missed");

    property p_brake;
        @(posedge core_clk_i) disable iff (!rstn_i)
        state_q == SPL_DECEL && poweroff_stop_action_i == 4'h1 |=> brake_mode_o == SPL_BRAKE_FREE;
    endproperty
    a_brake: assert property (p_brake) else $error("brake wrong");

    property p_hold;
        @(posedge core_clk_i) disable iff (!rstn_i)
        poweroff_stop_action_i inside {[4'h4:4'h7]} |=> !deviation_clear_o;
    endproperty
    a_hold: assert property (p_hold) else $error("hold cleared");

    property p_done;
        @(posedge core_clk_i) disable iff (!rstn_i)
        !cmd_done_i |=> !done_q;
    endproperty
    a_done: assert property (p_done) else $error("done early");
endmodule

/* testbench/spl_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// Host motion controller model
// ==========================================
// Issues position commands and samples the shared status pin each cycle
module spl_host_model (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic status_pin_i,
    output logic cmd_done_o,
    output logic [spl_pkg::DEV_W-1:0] deviation_o,
    output logic pin_seen_o
);
    import spl_pkg::*;
    // Command state held until the next call, like a real controller
    initial begin
        cmd_done_o = 1'b0;
        deviation_o = '0;
    end
    // Set command-finished flag and the current deviation
    task automatic issue(input logic done, input logic [DEV_W-1:0] dev);
        cmd_done_o = done;
        deviation_o = dev;
    endtask
    // Registered view of the pin, as the controller's input stage sees it
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_seen_o <= 1'b0;
        end else begin
            pin_seen_o <= status_pin_i;
        end
    end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import spl_pkg::*;
    // ==========================================
    // Signals
    // ==========================================
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sel = status_sel_reset;
    logic [POS_RANGE_W-1:0] range = 15'h0064; // In-position range, varied to prove it is used
    logic resp = 1'b1;
    logic [3:0] action = 4'h0;
    logic [DETECT_W-1:0] detect = 16'h0000;
    logic power_ok = 1'b1;
    logic bus_uv = 1'b0;
    logic servo_on = 1'b0;
    logic stalled = 1'b0;
    logic alarm_clear = 1'b0;
    logic cmd_done;
    logic [DEV_W-1:0] deviation;
    logic pin_seen;
    logic status_pin, alarm, servo_en, dev_clear;
    logic [1:0] brake;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    // ==========================================
    // Design and host model
    // ==========================================
    spl_power_loss u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .status_pin_select_i(sel),
        .undervoltage_response_select_i(resp), .poweroff_stop_action_i(action),
        .poweroff_detect_time_i(detect), .main_power_ok_i(power_ok), .bus_undervoltage_i(bus_uv),
        .servo_on_i(servo_on), .cmd_done_i(cmd_done), .motor_stalled_i(stalled), .deviation_i(deviation),
        .in_position_range_i(range), .alarm_clear_i(alarm_clear), .status_pin_o(status_pin),
        .main_undervoltage_alarm_o(alarm), .servo_enable_o(servo_en), .brake_mode_o(brake),
        .deviation_clear_o(dev_clear));
    spl_host_model u_host (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .status_pin_i(status_pin),
        .cmd_done_o(cmd_done), .deviation_o(deviation), .pin_seen_o(pin_seen));
    // ==========================================
    // Clock and timeout
    // ==========================================
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    // Cut a hang short well past the expected run length
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles >= 5000) begin
            mismatches++;
            finish_test();
        end
    end
    // ==========================================
    // Helpers
    // ==========================================
    // Advance n edges, then settle just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // Compare and count
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Pulse the trip clear once the cause has gone
    task automatic clear_trip();
        alarm_clear = 1'b1;
        step(1);
        alarm_clear = 1'b0;
        step(4);
    endtask
    // Expected braking per stop action
    function automatic logic [1:0] decel_exp(input logic [3:0] a);
        return (a >= 4'h8) ? SPL_BRAKE_EMERG : (a[0] ? SPL_BRAKE_FREE : SPL_BRAKE_DB);
    endfunction
    function automatic logic [1:0] stall_exp(input logic [3:0] a);
        return ((a >= 4'h8) ? a[0] : a[1]) ? SPL_BRAKE_FREE : SPL_BRAKE_DB;
    endfunction
    // Verdict
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        step(2);
        check(20'({status_pin, alarm, servo_en, brake, dev_clear}), 20'h0);
        rstn_i = 1'b1;
        step(3);
        // Position done: inclusive range, both signs, command pending
        u_host.issue(1'b1, 20'h00064);
        step(6);
        check(20'(pin_seen), 20'h1);
        u_host.issue(1'b1, 20'h00065);
        step(6);
        check(20'(pin_seen), 20'h0);
        // Widen the range by one: the same deviation now counts as done
        range = 15'h0065;
        step(6);
        check(20'(pin_seen), 20'h1);
        u_host.issue(1'b1, 20'hfff9c);
        step(6);
        check(20'(pin_seen), 20'h1);
        u_host.issue(1'b0, 20'h00000);
        step(6);
        check(20'(pin_seen), 20'h0);
        // Trip response at servo-on
        servo_on = 1'b1;
        step(8);
        check(20'(servo_en), 20'h1);
        power_ok = 1'b0;
        step(8);
        check(20'(alarm), 20'h1);
        check(20'(servo_en), 20'h0);
        power_ok = 1'b1;
        step(4);
        clear_trip();
        check(20'(alarm), 20'h0);
        // Soft servo-off through every stop action
        resp = 1'b0;
        sel = 1'b1;
        for (int a = 0; a <= 9; a++) begin
            action = 4'(a);
            power_ok = 1'b1;
            stalled = 1'b0;
            step(10);
            check(20'(servo_en), 20'h1);
            check(20'(pin_seen), 20'h0);
            power_ok = 1'b0;
            step(8);
            check(20'(servo_en), 20'h0);
            check(20'(alarm), 20'h0);
            check(20'(brake), 20'(decel_exp(action)));
            check(20'(dev_clear), 20'((action < 4'h4) || (action >= 4'h8)));
            check(20'(pin_seen), 20'h1);
            stalled = 1'b1;
            step(8);
            check(20'(brake), 20'(stall_exp(action)));
            check(20'(pin_seen), 20'h0);
        end
        power_ok = 1'b1;
        stalled = 1'b0;
        step(10);
        // Long detection time: no early alarm, bus undervoltage still trips
        detect = detect_time_invalid;
        power_ok = 1'b0;
        step(20);
        check(20'(alarm), 20'h0);
        check(20'(servo_en), 20'h1);
        bus_uv = 1'b1;
        step(8);
        check(20'(alarm), 20'h1);
        power_ok = 1'b1;
        bus_uv = 1'b0;
        step(4);
        clear_trip();
        check(20'(alarm), 20'h0);
        finish_test();
    end
endmodule
